// >>> rtl/ibe_pkg.sv
/*
  shared constants and types for the i2c master byte engine.
  assumes a 50 MHz clock and a classic 32-bit wishbone master.
*/
package ibe_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_BUF    = 8'h00;
  localparam logic [7:0] OFS_CTL2   = 8'h04;
  localparam logic [7:0] OFS_STAT   = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0c;
  localparam logic [7:0] OFS_RELOAD = 8'h10;
  localparam logic [7:0] OFS_CTL1   = 8'h14;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL2_SEN    = 0;
  localparam int CTL2_REPEATED_START_ENABLE   = 1;
  localparam int CTL2_PEN    = 2;
  localparam int CTL2_RECEIVE_ENABLE_BIT   = 3;
  localparam int CTL2_ACK_SEQUENCE_ENABLE  = 4;
  localparam int CTL2_ACK_DATA_BIT  = 5;
  localparam int CTL2_ACKST  = 6;
  localparam int STAT_BF     = 0;
  localparam int STAT_START  = 3;
  localparam int STAT_STOP   = 4;
  localparam int STAT_BUSY   = 7;
  localparam int FLG_PIF     = 0;
  localparam int FLG_WRITE_COLLISION_FLAG    = 1;
  localparam int FLG_OVF     = 2;
  localparam int FLG_BCL     = 3;
  localparam int CTL1_EN     = 0;
  localparam int CTL1_IE     = 1;
  localparam int RELOAD_W    = 7;
  localparam logic [6:0] RELOAD_RST = 7'h09;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS       = 20;
  localparam int HALF_TCY_NS  = 40;
  localparam int HALF_TCY_CYC = (HALF_TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int TCY_NS       = 2 * HALF_TCY_NS;
  localparam int WRITE_COLLISION_FLAG_WIN_NS  = 2 * TCY_NS;
  localparam int WRITE_COLLISION_FLAG_WIN_CYC = WRITE_COLLISION_FLAG_WIN_NS / CLK_NS;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_START_A, ST_START_B, ST_RS_A, ST_RS_B, ST_RS_C,
    ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH,
    ST_ACK_LOW, ST_ACK_HIGH, ST_STOP_A, ST_STOP_B, ST_STOP_C
  } ibe_state_e;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } ibe_drive_s;
endpackage

// >>> rtl/ibe_baud.sv
/*
  baud generator: reloadable down counter that stops at zero.
  assumes tick_i is a one-cycle enable at twice the instruction rate.
*/
`timescale 1ns/1ns
module ibe_baud #(
  parameter int W = 7
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] reload_i,
  output logic              timeout_o
);
  logic [W-1:0] cnt_ff;
  logic         run_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff    <= '0;
      run_ff    <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (load_i) begin
        cnt_ff <= reload_i;
        run_ff <= 1'b1;
      end else if (run_ff && tick_i) begin
        // a reload of zero is unsupported; it behaves as one
        if (cnt_ff <= W'(1)) begin
          cnt_ff    <= '0;
          run_ff    <= 1'b0;
          timeout_o <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - W'(1);
        end
      end
    end
  end
endmodule

// >>> rtl/ibe_engine.sv
/*
  i2c master byte engine: transmit, receive, acknowledge, stop,
  start and repeated start sequences, flags, bus monitor.
  assumes a classic wishbone master on clk_i and open-drain scl/sda
  pads resolved outside; pad inputs are asynchronous.
*/
// What this block does
// - write to buffer during repeated start sets collision flag, buffer kept
// - low five control-two bits ignored until repeated start completes
// - buffer write sets buffer full, starts baud generator and transmission
// - bit driven after scl falls; scl low one period, high one period
// - eighth falling edge clears buffer full and releases sda
// - ninth falling edge samples sda into ack status bit
// - after ninth clock set interrupt flag, hold scl low until next write
// - address is seven bits then read/write bit, then ack release
// - buffer write while shifting sets collision; updated only within 2 Tcy
// - collision flag only ever cleared by software
// - receive enable accepted only when module inactive
// - reception toggles scl, after eighth bit loads buffer and holds scl
// - received byte sets buffer full; buffer read clears it
// - overflow set when byte completes while buffer full still set
// - buffer write during reception sets collision flag, buffer kept
// - ack sequence drives ack data, one low and one high period, idles
// - buffer write during ack or stop sequence sets collision, discarded
// - stop: sda low, scl released, sda released, stop bit, then interrupt
// - reset or disable aborts transfer and clears start and stop bits
// - stop detected while bus busy and interrupts enabled raises flag
// - driven sda compared to sampled sda; mismatch sets bus collision
// - baud reload is low seven bits, counts to zero, stops until reload
// - baud generator decrements twice per instruction cycle
`timescale 1ns/1ns
module ibe_engine (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             sda_o,
  output logic             sda_oe_o
);
  // ****************************************
  // pad synchronisers and bus monitor
  // ****************************************
  logic scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff, sda_d_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  wire start_det = scl_s_ff && sda_d_ff && !sda_s_ff;
  wire stop_det  = scl_s_ff && !sda_d_ff && sda_s_ff;

  // ****************************************
  // half instruction cycle divider
  // ****************************************
  logic [3:0] div_ff;
  logic       tick_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == 4'(ibe_pkg::HALF_TCY_CYC - 1)) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 4'h1;
      tick_ff <= 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] buf_ff, shift_ff;
  logic [6:0] reload_ff;
  logic [4:0] en_ff;
  logic       ack_data_bit_ff, ack_status_bit_ff, port_en_ff, ie_ff;
  logic       bf_ff, start_seen_ff, stop_seen_ff;
  logic       pif_ff, write_collision_flag_ff, ovf_ff, bcl_ff;
  logic [3:0] since_wr_ff;
  ibe_pkg::ibe_state_e state_ff;
  ibe_pkg::ibe_drive_s drv_ff;
  logic       done_ff, pif_set_ff, bcl_set_ff, bf_clr_ff, rx_load_ff, go_ff;
  logic [3:0] bit_ff;

  wire req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr       = req && wb_we_i && wb_sel_i[0];
  wire rd       = req && !wb_we_i;
  wire idle     = (state_ff == ibe_pkg::ST_IDLE) && !done_ff;
  wire buf_wr   = wr && (wb_adr_i == ibe_pkg::OFS_BUF);
  wire buf_rd   = rd && (wb_adr_i == ibe_pkg::OFS_BUF);
  wire ctl2_wr  = wr && (wb_adr_i == ibe_pkg::OFS_CTL2);
  wire flg_wr   = wr && (wb_adr_i == ibe_pkg::OFS_FLAGS);
  wire tx_state = (state_ff == ibe_pkg::ST_TX_LOW) || (state_ff == ibe_pkg::ST_TX_HIGH);
  wire tx_go    = buf_wr && idle && port_en_ff && (en_ff == 5'h00);
  wire buf_coll = buf_wr && !tx_go;
  wire win_open = since_wr_ff < 4'(ibe_pkg::WRITE_COLLISION_FLAG_WIN_CYC);

  // wishbone answer: one wait state, ack for one cycle, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        case (wb_adr_i)
          ibe_pkg::OFS_BUF:    wb_dat_o <= {24'h0, buf_ff};
          ibe_pkg::OFS_CTL2:   wb_dat_o <= {25'h0, ack_status_bit_ff, ack_data_bit_ff, en_ff};
          ibe_pkg::OFS_STAT:   wb_dat_o <= {24'h0, !idle, 2'b00, stop_seen_ff,
                                            start_seen_ff, 2'b00, bf_ff};
          ibe_pkg::OFS_FLAGS:  wb_dat_o <= {28'h0, bcl_ff, ovf_ff, write_collision_flag_ff, pif_ff};
          ibe_pkg::OFS_RELOAD: wb_dat_o <= {25'h0, reload_ff};
          ibe_pkg::OFS_CTL1:   wb_dat_o <= {30'h0, ie_ff, port_en_ff};
          default:             wb_dat_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_ff  <= ibe_pkg::RELOAD_RST;
      port_en_ff <= 1'b0;
      ie_ff      <= 1'b0;
      ack_data_bit_ff   <= 1'b0;
    end else begin
      if (wr && wb_adr_i == ibe_pkg::OFS_RELOAD)
        reload_ff <= wb_dat_i[6:0];
      if (wr && wb_adr_i == ibe_pkg::OFS_CTL1) begin
        port_en_ff <= wb_dat_i[ibe_pkg::CTL1_EN];
        ie_ff      <= wb_dat_i[ibe_pkg::CTL1_IE];
      end
      if (ctl2_wr)
        ack_data_bit_ff <= wb_dat_i[ibe_pkg::CTL2_ACK_DATA_BIT];
    end
  end

  // ****************************************
  // sequence enables: one pending at a time, no queueing
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_ff) begin
      en_ff <= '0;
    end else if (done_ff) begin
      en_ff <= '0;
    end else if (ctl2_wr && idle && en_ff == 5'h00) begin
      if (wb_dat_i[ibe_pkg::CTL2_SEN])
        en_ff <= 5'h01 << ibe_pkg::CTL2_SEN;
      else if (wb_dat_i[ibe_pkg::CTL2_REPEATED_START_ENABLE])
        en_ff <= 5'h01 << ibe_pkg::CTL2_REPEATED_START_ENABLE;
      else if (wb_dat_i[ibe_pkg::CTL2_PEN])
        en_ff <= 5'h01 << ibe_pkg::CTL2_PEN;
      else if (wb_dat_i[ibe_pkg::CTL2_ACK_SEQUENCE_ENABLE])
        en_ff <= 5'h01 << ibe_pkg::CTL2_ACK_SEQUENCE_ENABLE;
      else if (wb_dat_i[ibe_pkg::CTL2_RECEIVE_ENABLE_BIT])
        en_ff <= 5'h01 << ibe_pkg::CTL2_RECEIVE_ENABLE_BIT;
    end
  end

  // ****************************************
  // transfer buffer and late-write window
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_ff      <= '0;
      since_wr_ff <= '1;
    end else begin
      if (buf_wr)
        since_wr_ff <= '0;
      else if (since_wr_ff != 4'hf)
        since_wr_ff <= since_wr_ff + 4'h1;
      if (tx_go || (buf_coll && tx_state && win_open))
        buf_ff <= wb_dat_i[7:0];
      else if (rx_load_ff && !bf_ff)
        buf_ff <= shift_ff;
    end
  end

  // ****************************************
  // status flags: hardware set wins over software clear
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bf_ff  <= 1'b0;
      pif_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      ovf_ff <= 1'b0;
      bcl_ff <= 1'b0;
    end else begin
      if (tx_go || (rx_load_ff && !bf_ff))
        bf_ff <= 1'b1;
      else if (bf_clr_ff || (buf_rd && !tx_state))
        bf_ff <= 1'b0;
      if (pif_set_ff || (stop_det && start_seen_ff && ie_ff))
        pif_ff <= 1'b1;
      else if (flg_wr && wb_dat_i[ibe_pkg::FLG_PIF])
        pif_ff <= 1'b0;
      if (buf_coll)
        write_collision_flag_ff <= 1'b1;
      else if (flg_wr && wb_dat_i[ibe_pkg::FLG_WRITE_COLLISION_FLAG])
        write_collision_flag_ff <= 1'b0;
      if (rx_load_ff && bf_ff)
        ovf_ff <= 1'b1;
      else if (flg_wr && wb_dat_i[ibe_pkg::FLG_OVF])
        ovf_ff <= 1'b0;
      if (bcl_set_ff)
        bcl_ff <= 1'b1;
      else if (flg_wr && wb_dat_i[ibe_pkg::FLG_BCL])
        bcl_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_ff) begin
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b0;
    end else if (start_det) begin
      start_seen_ff <= 1'b1;
      stop_seen_ff  <= 1'b0;
    end else if (stop_det) begin
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b1;
    end
  end

  // ****************************************
  // baud generator
  // ****************************************
  logic brg_to;
  wire  high_wait = !scl_s_ff && ((state_ff == ibe_pkg::ST_TX_HIGH) ||
                    (state_ff == ibe_pkg::ST_RX_HIGH) || (state_ff == ibe_pkg::ST_ACK_HIGH) ||
                    (state_ff == ibe_pkg::ST_RS_B) || (state_ff == ibe_pkg::ST_STOP_B));
  // clock stretching by a slave keeps the count reloaded until scl is high
  wire  brg_load  = go_ff || high_wait;

  ibe_baud #(
    .W (ibe_pkg::RELOAD_W)
  ) u_baud (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick_ff),
    .load_i    (brg_load),
    .reload_i  (reload_ff),
    .timeout_o (brg_to)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_ff) begin
      state_ff   <= ibe_pkg::ST_IDLE;
      drv_ff     <= '0;
      shift_ff   <= '0;
      bit_ff     <= '0;
      ack_status_bit_ff <= 1'b0;
      go_ff      <= 1'b0;
      done_ff    <= 1'b0;
      pif_set_ff <= 1'b0;
      bcl_set_ff <= 1'b0;
      bf_clr_ff  <= 1'b0;
      rx_load_ff <= 1'b0;
    end else begin
      go_ff      <= 1'b0;
      done_ff    <= 1'b0;
      pif_set_ff <= 1'b0;
      bcl_set_ff <= 1'b0;
      bf_clr_ff  <= 1'b0;
      rx_load_ff <= 1'b0;
      case (state_ff)
        ibe_pkg::ST_IDLE: begin
          if (tx_go) begin
            shift_ff <= wb_dat_i[7:0];
            bit_ff   <= '0;
            drv_ff.scl_oe <= 1'b1;
            go_ff    <= 1'b1;
            state_ff <= ibe_pkg::ST_TX_LOW;
          end else if (!done_ff && en_ff[ibe_pkg::CTL2_SEN]) begin
            if (!sda_s_ff || !scl_s_ff) begin
              bcl_set_ff <= 1'b1;
              done_ff    <= 1'b1;
            end else begin
              go_ff    <= 1'b1;
              state_ff <= ibe_pkg::ST_START_A;
            end
          end else if (!done_ff && en_ff[ibe_pkg::CTL2_REPEATED_START_ENABLE]) begin
            drv_ff   <= '{scl_oe: 1'b1, sda_oe: 1'b0};
            go_ff    <= 1'b1;
            state_ff <= ibe_pkg::ST_RS_A;
          end else if (!done_ff && en_ff[ibe_pkg::CTL2_PEN]) begin
            drv_ff   <= '{scl_oe: 1'b1, sda_oe: 1'b1};
            state_ff <= ibe_pkg::ST_STOP_A;
          end else if (!done_ff && en_ff[ibe_pkg::CTL2_ACK_SEQUENCE_ENABLE]) begin
            drv_ff   <= '{scl_oe: 1'b1, sda_oe: !ack_data_bit_ff};
            go_ff    <= 1'b1;
            state_ff <= ibe_pkg::ST_ACK_LOW;
          end else if (!done_ff && en_ff[ibe_pkg::CTL2_RECEIVE_ENABLE_BIT]) begin
            drv_ff   <= '{scl_oe: 1'b1, sda_oe: 1'b0};
            bit_ff   <= '0;
            go_ff    <= 1'b1;
            state_ff <= ibe_pkg::ST_RX_LOW;
          end
        end
        ibe_pkg::ST_START_A: if (brg_to) begin
          if (sda_s_ff && scl_s_ff) begin
            drv_ff.sda_oe <= 1'b1;
            go_ff    <= 1'b1;
            state_ff <= ibe_pkg::ST_START_B;
          end else begin
            bcl_set_ff <= 1'b1;
            done_ff    <= 1'b1;
            drv_ff     <= '0;
            state_ff   <= ibe_pkg::ST_IDLE;
          end
        end
        ibe_pkg::ST_START_B, ibe_pkg::ST_RS_C: if (brg_to) begin
          done_ff    <= 1'b1;
          pif_set_ff <= 1'b1;
          state_ff   <= ibe_pkg::ST_IDLE;
        end
        ibe_pkg::ST_RS_A: if (brg_to) begin
          drv_ff.scl_oe <= 1'b0;
          state_ff <= ibe_pkg::ST_RS_B;
        end
        ibe_pkg::ST_RS_B: begin
          if (scl_s_ff && !sda_s_ff) begin
            bcl_set_ff <= 1'b1;
            done_ff    <= 1'b1;
            drv_ff     <= '0;
            state_ff   <= ibe_pkg::ST_IDLE;
          end else if (brg_to) begin
            drv_ff.sda_oe <= 1'b1;
            go_ff    <= 1'b1;
            state_ff <= ibe_pkg::ST_RS_C;
          end
        end
        ibe_pkg::ST_TX_LOW: begin
          // bit 8 is the slave's acknowledge slot, so sda is released
          drv_ff.sda_oe <= (bit_ff < 4'h8) && !shift_ff[7];
          if (brg_to) begin
            drv_ff.scl_oe <= 1'b0;
            state_ff <= ibe_pkg::ST_TX_HIGH;
          end
        end
        ibe_pkg::ST_TX_HIGH: begin
          if (scl_s_ff && bit_ff < 4'h8 && !drv_ff.sda_oe && !sda_s_ff) begin
            bcl_set_ff <= 1'b1;
            bf_clr_ff  <= 1'b1;
            drv_ff     <= '0;
            state_ff   <= ibe_pkg::ST_IDLE;
          end else if (brg_to) begin
            drv_ff.scl_oe <= 1'b1;
            if (bit_ff == 4'h8) begin
              ack_status_bit_ff <= sda_s_ff;
              pif_set_ff <= 1'b1;
              state_ff   <= ibe_pkg::ST_IDLE;
            end else begin
              if (bit_ff == 4'h7)
                bf_clr_ff <= 1'b1;
              shift_ff <= {shift_ff[6:0], 1'b0};
              bit_ff   <= bit_ff + 4'h1;
              go_ff    <= 1'b1;
              state_ff <= ibe_pkg::ST_TX_LOW;
            end
          end
        end
        ibe_pkg::ST_RX_LOW: if (brg_to) begin
          drv_ff.scl_oe <= 1'b0;
          state_ff <= ibe_pkg::ST_RX_HIGH;
        end
        ibe_pkg::ST_RX_HIGH: if (brg_to) begin
          drv_ff.scl_oe <= 1'b1;
          shift_ff <= {shift_ff[6:0], sda_s_ff};
          if (bit_ff == 4'h7) begin
            rx_load_ff <= 1'b1;
            pif_set_ff <= 1'b1;
            done_ff    <= 1'b1;
            state_ff   <= ibe_pkg::ST_IDLE;
          end else begin
            bit_ff   <= bit_ff + 4'h1;
            go_ff    <= 1'b1;
            state_ff <= ibe_pkg::ST_RX_LOW;
          end
        end
        ibe_pkg::ST_ACK_LOW: if (brg_to) begin
          drv_ff.scl_oe <= 1'b0;
          state_ff <= ibe_pkg::ST_ACK_HIGH;
        end
        ibe_pkg::ST_ACK_HIGH: begin
          if (scl_s_ff && !drv_ff.sda_oe && !sda_s_ff) begin
            bcl_set_ff <= 1'b1;
            done_ff    <= 1'b1;
            drv_ff     <= '0;
            state_ff   <= ibe_pkg::ST_IDLE;
          end else if (brg_to) begin
            drv_ff.scl_oe <= 1'b1;
            done_ff  <= 1'b1;
            state_ff <= ibe_pkg::ST_IDLE;
          end
        end
        ibe_pkg::ST_STOP_A: begin
          if (!sda_s_ff && !go_ff && !brg_to && bit_ff != 4'hf) begin
            go_ff  <= 1'b1;
            bit_ff <= 4'hf; // marks the count as started
          end else if (brg_to) begin
            drv_ff.scl_oe <= 1'b0;
            bit_ff   <= '0;
            state_ff <= ibe_pkg::ST_STOP_B;
          end
        end
        ibe_pkg::ST_STOP_B: if (brg_to) begin
          drv_ff.sda_oe <= 1'b0;
          go_ff    <= 1'b1;
          state_ff <= ibe_pkg::ST_STOP_C;
        end
        ibe_pkg::ST_STOP_C: if (brg_to) begin
          done_ff  <= 1'b1;
          state_ff <= ibe_pkg::ST_IDLE;
          if (!sda_s_ff)
            bcl_set_ff <= 1'b1;
          else
            pif_set_ff <= 1'b1;
        end
        default: state_ff <= ibe_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // pads: open drain, data output fixed low
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= drv_ff.scl_oe && port_en_ff;
      sda_oe_o <= drv_ff.sda_oe && port_en_ff;
    end
  end
endmodule

// >>> dv/ibe_asserts.sv
/*
  port checker for ibe_engine: bus handshake, pin drive, reset.
  assumes it is bound to every ibe_engine instance.
*/
`timescale 1ns/1ns
module ibe_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_out_of_rst;
    $fell(rst_i);
  endsequence
  property p_ans;  s_req |=> wb_ack_o; endproperty
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_quiet; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  property p_od; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  // shortest legal baud period is two clocks (reload 1)
  property p_scl_low; $rose(scl_oe_o) |-> scl_oe_o [*2]; endproperty
  property p_scl_high; $fell(scl_oe_o) |-> !scl_oe_o [*2]; endproperty
  property p_rst_pins; s_out_of_rst |-> !scl_oe_o && !sda_oe_o; endproperty
  property p_rst_ack; s_out_of_rst |-> !wb_ack_o; endproperty
  a_ans: assert property (p_ans) else $error("no ack after request");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_quiet: assert property (p_quiet) else $error("ack without request");
  a_od: assert property (p_od) else $error("pin data not low");
  a_scl_low: assert property (p_scl_low) else $error("scl low too short");
  a_scl_high: assert property (p_scl_high) else $error("scl high too short");
  a_rst_pins: assert property (p_rst_pins) else $error("lines held after reset");
  a_rst_ack: assert property (p_rst_ack) else $error("ack after reset");
endmodule
bind ibe_engine ibe_asserts ibe_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// >>> dv/ibe_slave.sv
/*
  behavioural i2c slave: acks or nacks written bytes, sends a read byte.
  assumes open-drain wires with pull-ups; pull_o high pulls sda low.
*/
`timescale 1ns/1ns
module ibe_slave (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       rd_i,
  input  wire logic       nack_i,
  input  wire logic [7:0] rd_byte_i,
  output logic            pull_o,
  output logic [7:0]      got_o
);
  int cnt = 0;
  initial pull_o = 1'b0;
  // a start condition realigns the bit count
  always @(negedge sda_i) if (scl_i) cnt = 0;
  always @(posedge scl_i) begin
    if (cnt < 8) got_o = {got_o[6:0], sda_i};
    cnt = cnt + 1;
  end
  // changes come a hold time after scl falls, never while scl is high
  always @(negedge scl_i or posedge rd_i) #100 begin
    if (cnt == 9) cnt = 0;
    pull_o = (cnt == 8) ? (!rd_i && !nack_i) : (rd_i && cnt < 8 && !rd_byte_i[7-cnt]);
  end
endmodule

// >>> dv/ibe_engine_tb.sv
/*
  self-checking bench for ibe_engine: tx, rx, ack, stop, flags.
  assumes the slave model on open-drain lines with pull-ups.
*/
`timescale 1ns/1ns
module ibe_engine_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, scl_oe, sda_oe, pull, rd_m, nack;
  logic [7:0]  adr, got;
  logic [31:0] dat, rdat, q;
  int          miscompares = 0, checks = 0, cyc_n = 0;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe | pull);
  ibe_engine ibe_engine_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe), .sda_o(),
    .sda_oe_o(sda_oe));
  ibe_slave ibe_slave_i (.scl_i(scl), .sda_i(sda), .rd_i(rd_m), .nack_i(nack),
    .rd_byte_i(8'hc5), .pull_o(pull), .got_o(got));
  // ********************
  // clock, timeout, tasks
  // ********************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e, input string n);
    wb(1'b0, a, 32'h0);
    check(n, q & m, e);
  endtask
  // polling is bounded by the cycle timeout only
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    do wb(1'b0, a, 32'h0); while (q[b] !== v);
  endtask
  // ********************
  // tests
  // ********************
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0;
    rd_m = 1'b0; nack = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ibe_pkg::OFS_RELOAD, 32'hff, 32'h09, "reload");
    rchk(ibe_pkg::OFS_STAT, 32'hff, 32'h00, "stat reset");
    rchk(8'h40, 32'hffffffff, 32'h0, "unmapped");
    wb(1'b1, ibe_pkg::OFS_CTL1, 32'h3);
    wb(1'b1, ibe_pkg::OFS_CTL2, 32'h1);
    poll(ibe_pkg::OFS_FLAGS, ibe_pkg::FLG_PIF, 1'b1);
    wb(1'b1, ibe_pkg::OFS_FLAGS, 32'hf);
    wb(1'b1, ibe_pkg::OFS_BUF, 32'ha4);
    rchk(ibe_pkg::OFS_STAT, 32'h1, 32'h1, "bf tx");
    repeat (40) @(posedge clk_i);
    wb(1'b1, ibe_pkg::OFS_BUF, 32'h11);
    poll(ibe_pkg::OFS_FLAGS, ibe_pkg::FLG_PIF, 1'b1);
    check("address", got, 8'ha4);
    rchk(ibe_pkg::OFS_CTL2, 32'h40, 32'h0, "ack seen");
    rchk(ibe_pkg::OFS_STAT, 32'h1, 32'h0, "bf done");
    rchk(ibe_pkg::OFS_FLAGS, 32'h3, 32'h3, "pif write_collision_flag");
    wb(1'b1, ibe_pkg::OFS_FLAGS, 32'hf);
    nack <= 1'b1;
    wb(1'b1, ibe_pkg::OFS_BUF, 32'h3c);
    wb(1'b1, ibe_pkg::OFS_BUF, 32'h55);
    rchk(ibe_pkg::OFS_BUF, 32'hff, 32'h55, "late write");
    poll(ibe_pkg::OFS_FLAGS, ibe_pkg::FLG_PIF, 1'b1);
    check("data", got, 8'h3c);
    rchk(ibe_pkg::OFS_CTL2, 32'h40, 32'h40, "nack seen");
    wb(1'b1, ibe_pkg::OFS_FLAGS, 32'hf);
    rd_m <= 1'b1;
    wb(1'b1, ibe_pkg::OFS_CTL2, 32'h8);
    wb(1'b1, ibe_pkg::OFS_BUF, 32'h77);
    poll(ibe_pkg::OFS_FLAGS, ibe_pkg::FLG_PIF, 1'b1);
    rchk(ibe_pkg::OFS_CTL2, 32'h8, 32'h0, "receive_enable_bit clr");
    rchk(ibe_pkg::OFS_FLAGS, 32'h6, 32'h2, "write_collision_flag rx");
    rchk(ibe_pkg::OFS_STAT, 32'h1, 32'h1, "bf rx");
    wb(1'b1, ibe_pkg::OFS_FLAGS, 32'hf);
    wb(1'b1, ibe_pkg::OFS_CTL2, 32'h10);
    do @(posedge clk_i); while (scl !== 1'b1);
    check("ack bit", sda, 1'b0);
    wb(1'b1, ibe_pkg::OFS_BUF, 32'h5a);
    wb(1'b1, ibe_pkg::OFS_CTL2, 32'h8);
    poll(ibe_pkg::OFS_CTL2, ibe_pkg::CTL2_ACK_SEQUENCE_ENABLE, 1'b0);
    rchk(ibe_pkg::OFS_CTL2, 32'h8, 32'h0, "receive_enable_bit busy");
    rchk(ibe_pkg::OFS_FLAGS, 32'h2, 32'h2, "write_collision_flag ack");
    wb(1'b1, ibe_pkg::OFS_FLAGS, 32'hf);
    wb(1'b1, ibe_pkg::OFS_CTL2, 32'h8);
    poll(ibe_pkg::OFS_FLAGS, ibe_pkg::FLG_PIF, 1'b1);
    rchk(ibe_pkg::OFS_FLAGS, 32'h4, 32'h4, "overflow");
    rchk(ibe_pkg::OFS_BUF, 32'hff, 32'hc5, "rx byte");
    rchk(ibe_pkg::OFS_STAT, 32'h1, 32'h0, "bf read");
    rd_m <= 1'b0;
    wb(1'b1, ibe_pkg::OFS_FLAGS, 32'hf);
    wb(1'b1, ibe_pkg::OFS_CTL2, 32'h4);
    poll(ibe_pkg::OFS_FLAGS, ibe_pkg::FLG_PIF, 1'b1);
    rchk(ibe_pkg::OFS_STAT, 32'h10, 32'h10, "stop seen");
    // the stop detector raises the flag first; clear it and wait for the sequence end
    wb(1'b1, ibe_pkg::OFS_FLAGS, 32'h1);
    poll(ibe_pkg::OFS_FLAGS, ibe_pkg::FLG_PIF, 1'b1);
    rchk(ibe_pkg::OFS_CTL2, 32'h4, 32'h0, "pen clr");
    wb(1'b1, ibe_pkg::OFS_CTL1, 32'h0);
    rchk(ibe_pkg::OFS_STAT, 32'h18, 32'h0, "disabled");
    print_verdict();
  end
endmodule
